//--- rtl/keypad_pkg.sv
// Constants, codes and timing for the keypad command unit.
// Assumes a 250 MHz system clock and a host link delivering whole bytes.
//
// How it works
// - Bytes 254 65 select automatic mode, sending each key code at once; default.
// - Bytes 254 79 stop unprompted sending; events go into a ten-entry buffer.
// - Poll 254 38 returns the oldest unread buffered code and removes it.
// - Poll answer MSB is one while further codes remain, zero on the last.
// - Poll of an empty buffer answers zero.
// - Clear-buffer command empties the key buffer.
// - Debounce byte times 6.554 us is the settling wait before accepting keys.
// - Debounce count is 8 after reset.
// - Bytes 254 126 plus one byte: 1 hold, 0 typematic; typematic default.
// - Typematic: code sent at once, then five per second after one second.
// - Hold: key-down code once on press, key-up code once on release.
// - A command disables repetition; repetition is on, typematic, after reset.
// - Bytes 254 213 then 25 down bytes then 25 up bytes, row-major order.
// - An assignment byte of 255 keeps that key's existing code.
// - Reset key-down codes are 65 to 89 in scan order.
// - Reset key-up codes are 97 to 121 in scan order.
package keypad_pkg;
    // --------------------------------------------------------------
    // Key matrix and buffer shape
    // --------------------------------------------------------------
    localparam int          KEYS         = 25;
    localparam int          BUF_DEPTH    = 10;
    localparam int          KEY_IDX_W    = 5;
    localparam int          BUF_CNT_W    = 4;

    // --------------------------------------------------------------
    // Command bytes
    // --------------------------------------------------------------
    localparam logic [7:0]  CMD_PREFIX   = 8'hFE;
    localparam logic [7:0]  CMD_AUTO_ON  = 8'h41;
    localparam logic [7:0]  CMD_AUTO_OFF = 8'h4F;
    localparam logic [7:0]  CMD_POLL     = 8'h26;
    localparam logic [7:0]  CMD_CLEAR    = 8'h45;
    localparam logic [7:0]  CMD_DEBOUNCE = 8'h55;
    localparam logic [7:0]  CMD_RPT_MODE = 8'h7E;
    localparam logic [7:0]  CMD_RPT_OFF  = 8'h60;
    localparam logic [7:0]  CMD_ASSIGN   = 8'hD5;

    // --------------------------------------------------------------
    // Codes and reset values
    // --------------------------------------------------------------
    localparam logic [7:0]  KEEP_CODE    = 8'hFF;
    localparam logic [7:0]  DOWN_BASE    = 8'h41;
    localparam logic [7:0]  UP_BASE      = 8'h61;
    localparam logic [7:0]  DEBOUNCE_RST = 8'h08;
    localparam logic [7:0]  MORE_FLAG    = 8'h80;
    localparam logic [7:0]  EMPTY_ANSWER = 8'h00;
    localparam logic [5:0]  ASSIGN_LAST  = 6'h31;

    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam longint      CLK_PERIOD_PS     = 4000;
    localparam longint      DEBOUNCE_STEP_PS  = 6554000;
    localparam longint      REPEAT_DELAY_MS   = 1000;
    localparam longint      REPEAT_RATE_HZ    = 5;
    localparam longint      PS_PER_MS         = 1000000000;
    localparam longint      PS_PER_S          = 1000000000000;
    localparam int          STEP_CYCLES  = int'((DEBOUNCE_STEP_PS + CLK_PERIOD_PS - 1)
                                               / CLK_PERIOD_PS);
    localparam int          DELAY_CYCLES = int'((REPEAT_DELAY_MS * PS_PER_MS)
                                               / CLK_PERIOD_PS);
    localparam int          RATE_CYCLES  = int'(PS_PER_S / (REPEAT_RATE_HZ * CLK_PERIOD_PS));
endpackage : keypad_pkg

//--- rtl/key_code_table.sv
// Assignable key-down and key-up code table.
// Assumes writes and reads come from logic on the same clock.
`timescale 1ns/1ps
module key_code_table
    import keypad_pkg::*;
#(
    parameter int KEY_COUNT = KEYS
) (
    input  wire logic                 mclk,
    input  wire logic                 reset,
    input  wire logic                 wrEn,
    input  wire logic                 wrUp,
    input  wire logic [KEY_IDX_W-1:0] wrIdx,
    input  wire logic [7:0]           wrData,
    input  wire logic                 rdEn,
    input  wire logic                 rdUp,
    input  wire logic [KEY_IDX_W-1:0] rdIdx,
    output logic      [7:0]           rdData,
    output logic                      rdValid
);
    logic [7:0] downMem_q [KEY_COUNT];
    logic [7:0] upMem_q   [KEY_COUNT];

    // Table storage with scan-order defaults
    always_ff @(posedge mclk) begin
        for (int i = 0; i < KEY_COUNT; i++) begin
            if (reset) begin
                downMem_q[i] <= DOWN_BASE + 8'(i);
                upMem_q[i]   <= UP_BASE + 8'(i);
            end else if (wrEn && !wrUp && wrIdx == KEY_IDX_W'(i)
                         && wrData != KEEP_CODE) begin
                downMem_q[i] <= wrData;
            end else if (wrEn && wrUp && wrIdx == KEY_IDX_W'(i)
                         && wrData != KEEP_CODE) begin
                upMem_q[i]   <= wrData;
            end
        end
    end

    // Registered read port
    always_ff @(posedge mclk) begin
        if (reset) begin
            rdData  <= 8'h00;
            rdValid <= 1'b0;
        end else begin
            rdValid <= rdEn;
            if (rdEn) begin
                rdData <= rdUp ? upMem_q[rdIdx] : downMem_q[rdIdx];
            end
        end
    end
endmodule : key_code_table

//--- rtl/key_event_fifo.sv
// Small key event buffer with registered read data.
// Pops when empty are ignored; full drops pushes.
`timescale 1ns/1ps
module key_event_fifo
    import keypad_pkg::*;
#(
    parameter int DEPTH = BUF_DEPTH,
    parameter int WIDTH = 8
) (
    input  wire logic                 mclk,
    input  wire logic                 reset,
    input  wire logic                 clear,
    input  wire logic                 push,
    input  wire logic [WIDTH-1:0]     pushData,
    input  wire logic                 pop,
    output logic      [WIDTH-1:0]     popData,
    output logic      [BUF_CNT_W-1:0] count
);
    logic [WIDTH-1:0]     mem_q [DEPTH];
    logic [BUF_CNT_W-1:0] wrPtr_q;
    logic [BUF_CNT_W-1:0] rdPtr_q;

    wire doPush = push && count != BUF_CNT_W'(DEPTH);
    wire doPop  = pop && count != '0;
    wire [BUF_CNT_W-1:0] wrNext = (wrPtr_q == BUF_CNT_W'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
    wire [BUF_CNT_W-1:0] rdNext = (rdPtr_q == BUF_CNT_W'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;

    if (DEPTH < 2 || DEPTH >= (1 << BUF_CNT_W)) begin : g_bad_depth
        $error("key_event_fifo depth out of range");
    end

    // Storage
    always_ff @(posedge mclk) begin
        if (doPush) begin
            mem_q[wrPtr_q] <= pushData;
        end
    end

    // Pointers, count and read register
    always_ff @(posedge mclk) begin
        if (reset || clear) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count   <= '0;
            popData <= '0;
        end else begin
            if (doPush) wrPtr_q <= wrNext;
            if (doPop) begin
                rdPtr_q <= rdNext;
                popData <= mem_q[rdPtr_q];
            end
            count <= count + BUF_CNT_W'(doPush) - BUF_CNT_W'(doPop);
        end
    end
endmodule : key_event_fifo

//--- rtl/keypad_scan_command_unit.sv
// Keypad command unit: command parser, debounce, repeat and delivery.
// Assumes whole command bytes arrive as one-cycle strobes on mclk and
// raw key levels arrive asynchronously from the key matrix pins.
`timescale 1ns/1ps
module keypad_scan_command_unit
    import keypad_pkg::*;
#(
    parameter int STEP_CYC  = STEP_CYCLES,
    parameter int DELAY_CYC = DELAY_CYCLES,
    parameter int RATE_CYC  = RATE_CYCLES
) (
    input  wire logic                 mclk,
    input  wire logic                 reset,
    input  wire logic [7:0]           cmdByte,
    input  wire logic                 cmdValid,
    input  wire logic [KEYS-1:0]      keyRaw,
    output logic      [7:0]           txByte,
    output logic                      txValid,
    output logic                      autoMode,
    output logic                      holdMode,
    output logic                      repeatOn,
    output logic      [7:0]           debounceCount,
    output logic      [BUF_CNT_W-1:0] bufCount
);
    import keypad_pkg::*;

    if (STEP_CYC < 1 || DELAY_CYC < 1 || RATE_CYC < 1) begin : g_bad_timing
        $error("keypad timing counts must be at least one cycle");
    end

    // ----------------------------------------------------------------
    // Command parser state
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_PREFIX = 5'b00010,
        ST_DBARG  = 5'b00100,
        ST_RPTARG = 5'b01000,
        ST_ASSIGN = 5'b10000
    } parse_e;

    parse_e          state_q;
    parse_e          state_d;
    logic [5:0]      asgCnt_q;
    logic [KEYS-1:0] keyMeta_q;
    logic [KEYS-1:0] keySync_q;
    logic [KEYS-1:0] keyLast_q;
    logic [KEYS-1:0] keyStable_q;
    logic [KEYS-1:0] keyRep_q;
    logic [31:0]     stepCnt_q;
    logic [7:0]      dbTicks_q;
    logic [31:0]     repCnt_q;
    logic            repPhase_q;
    logic            activeValid_q;
    logic [KEY_IDX_W-1:0] activeKey_q;
    logic            lookReq_q;
    logic            lookUp_q;
    logic [KEY_IDX_W-1:0] lookIdx_q;
    logic            pollPend_q;
    logic            pollMore_q;
    logic            pollHad_q;
    logic [7:0]      codeData;
    logic            codeValid;
    logic [7:0]      fifoData;

    // Byte decode in the prefix and argument states
    wire inPrefix  = state_q == ST_PREFIX && cmdValid;
    wire autoOnCmd = inPrefix && cmdByte == CMD_AUTO_ON;
    wire autoOff   = inPrefix && cmdByte == CMD_AUTO_OFF;
    wire pollTake  = inPrefix && cmdByte == CMD_POLL;
    wire clearCmd  = inPrefix && cmdByte == CMD_CLEAR;
    wire rptOffCmd = inPrefix && cmdByte == CMD_RPT_OFF;
    wire dbArg     = state_q == ST_DBARG && cmdValid;
    wire rptArg    = state_q == ST_RPTARG && cmdValid;
    wire asgByte   = state_q == ST_ASSIGN && cmdValid;
    wire asgUp     = asgCnt_q >= 6'(KEYS);
    wire [KEY_IDX_W-1:0] asgIdx = asgUp ? KEY_IDX_W'(asgCnt_q - 6'(KEYS))
                                        : KEY_IDX_W'(asgCnt_q);

    // Next parser state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (cmdValid && cmdByte == CMD_PREFIX) state_d = ST_PREFIX;
            end
            ST_PREFIX: begin
                if (cmdValid) begin
                    if (cmdByte == CMD_DEBOUNCE)      state_d = ST_DBARG;
                    else if (cmdByte == CMD_RPT_MODE) state_d = ST_RPTARG;
                    else if (cmdByte == CMD_ASSIGN)   state_d = ST_ASSIGN;
                    else                              state_d = ST_IDLE;
                end
            end
            ST_DBARG:  if (cmdValid) state_d = ST_IDLE;
            ST_RPTARG: if (cmdValid) state_d = ST_IDLE;
            ST_ASSIGN: if (cmdValid && asgCnt_q == ASSIGN_LAST) state_d = ST_IDLE;
            default:   state_d = ST_IDLE;
        endcase
    end

    // Parser registers
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_q  <= ST_IDLE;
            asgCnt_q <= '0;
        end else begin
            state_q  <= state_d;
            if (state_q != ST_ASSIGN) asgCnt_q <= '0;
            else if (asgByte)         asgCnt_q <= asgCnt_q + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Configuration set by commands
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            autoMode      <= 1'b1;
            holdMode      <= 1'b0;
            repeatOn      <= 1'b1;
            debounceCount <= DEBOUNCE_RST;
        end else begin
            if (autoOnCmd) autoMode <= 1'b1;
            if (autoOff)   autoMode <= 1'b0;
            if (dbArg)     debounceCount <= cmdByte;
            if (rptArg) begin
                holdMode <= cmdByte[0];
                repeatOn <= 1'b1;
            end
            if (rptOffCmd) repeatOn <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Key input synchroniser and debounce
    // ----------------------------------------------------------------
    wire keyMoved = keySync_q != keyLast_q;
    wire stepDone = stepCnt_q == 32'(STEP_CYC - 1);
    wire settled  = dbTicks_q >= debounceCount;

    always_ff @(posedge mclk) begin
        if (reset) begin
            keyMeta_q   <= '0;
            keySync_q   <= '0;
            keyLast_q   <= '0;
            keyStable_q <= '0;
            stepCnt_q   <= '0;
            dbTicks_q   <= '0;
        end else begin
            keyMeta_q <= keyRaw;
            keySync_q <= keyMeta_q;
            keyLast_q <= keySync_q;
            if (keyMoved) begin
                stepCnt_q <= '0;
                dbTicks_q <= '0;
            end else if (!settled) begin
                stepCnt_q <= stepDone ? '0 : stepCnt_q + 1'b1;
                if (stepDone) dbTicks_q <= dbTicks_q + 1'b1;
            end else begin
                keyStable_q <= keyLast_q;
            end
        end
    end

    // ----------------------------------------------------------------
    // Event selection: lowest changed key first
    // ----------------------------------------------------------------
    wire [KEYS-1:0] keyDiff = keyStable_q ^ keyRep_q;
    logic [KEY_IDX_W-1:0] evIdx;

    always_comb begin
        evIdx = '0;
        for (int i = KEYS - 1; i >= 0; i--) begin
            if (keyDiff[i]) evIdx = KEY_IDX_W'(i);
        end
    end

    wire evFree    = !lookReq_q && !pollTake && !pollPend_q;
    wire evGo      = evFree && keyDiff != '0;
    wire evPress   = keyStable_q[evIdx];
    wire activeOn  = activeValid_q && keyRep_q[activeKey_q];
    wire repArm    = repeatOn && !holdMode && activeOn;
    wire [31:0] repLimit = repPhase_q ? 32'(RATE_CYC - 1) : 32'(DELAY_CYC - 1);
    wire repFire   = evFree && keyDiff == '0 && repArm && repCnt_q >= repLimit;

    // Event tracking, repeat timing and code lookup requests
    always_ff @(posedge mclk) begin
        if (reset) begin
            keyRep_q      <= '0;
            lookReq_q     <= 1'b0;
            lookUp_q      <= 1'b0;
            lookIdx_q     <= '0;
            activeValid_q <= 1'b0;
            activeKey_q   <= '0;
            repCnt_q      <= '0;
            repPhase_q    <= 1'b0;
        end else begin
            lookReq_q <= 1'b0;
            if (repArm && !repFire) repCnt_q <= repCnt_q + 1'b1;
            if (evGo) begin
                keyRep_q[evIdx] <= evPress;
                lookIdx_q       <= evIdx;
                lookUp_q        <= !evPress;
                if (evPress) begin
                    lookReq_q     <= 1'b1;
                    activeKey_q   <= evIdx;
                    activeValid_q <= 1'b1;
                    repCnt_q      <= '0;
                    repPhase_q    <= 1'b0;
                end else begin
                    lookReq_q <= holdMode && repeatOn;
                    if (evIdx == activeKey_q) activeValid_q <= 1'b0;
                end
            end else if (repFire) begin
                lookReq_q  <= 1'b1;
                lookIdx_q  <= activeKey_q;
                lookUp_q   <= 1'b0;
                repCnt_q   <= '0;
                repPhase_q <= 1'b1;
            end
        end
    end

    key_code_table u_table (
        .mclk    (mclk),
        .reset   (reset),
        .wrEn    (asgByte),
        .wrUp    (asgUp),
        .wrIdx   (asgIdx),
        .wrData  (cmdByte),
        .rdEn    (lookReq_q),
        .rdUp    (lookUp_q),
        .rdIdx   (lookIdx_q),
        .rdData  (codeData),
        .rdValid (codeValid)
    );

    // ----------------------------------------------------------------
    // Key buffer and poll answer
    // ----------------------------------------------------------------
    key_event_fifo u_fifo (
        .mclk     (mclk),
        .reset    (reset),
        .clear    (clearCmd),
        .push     (codeValid && !autoMode),
        .pushData (codeData),
        .pop      (pollTake),
        .popData  (fifoData),
        .count    (bufCount)
    );

    always_ff @(posedge mclk) begin
        if (reset) begin
            pollPend_q <= 1'b0;
            pollMore_q <= 1'b0;
            pollHad_q  <= 1'b0;
            txByte     <= 8'h00;
            txValid    <= 1'b0;
        end else begin
            pollPend_q <= pollTake;
            pollHad_q  <= bufCount != '0;
            pollMore_q <= bufCount > BUF_CNT_W'(1);
            txValid    <= pollPend_q || (codeValid && autoMode);
            if (pollPend_q) begin
                txByte <= !pollHad_q ? EMPTY_ANSWER
                        : pollMore_q ? (fifoData | MORE_FLAG)
                        : (fifoData & ~MORE_FLAG);
            end else if (codeValid && autoMode) begin
                txByte <= codeData;
            end
        end
    end
endmodule : keypad_scan_command_unit

//--- testbench/keypad_scan_command_unit_assertions.sv
// Concurrent checks on the keypad command unit ports.
// Assumes it is bound to every keypad_scan_command_unit instance.
`timescale 1ns/1ps
module keypad_scan_command_unit_checker (
    input wire logic                             mclk,
    input wire logic                             reset,
    input wire logic [7:0]                       cmdByte,
    input wire logic                             cmdValid,
    input wire logic [7:0]                       txByte,
    input wire logic                             txValid,
    input wire logic                             autoMode,
    input wire logic                             holdMode,
    input wire logic                             repeatOn,
    input wire logic [7:0]                       debounceCount,
    input wire logic [keypad_pkg::BUF_CNT_W-1:0] bufCount
);
    import keypad_pkg::*;
    // --------------------------------------------------------------
    // Port relations
    // --------------------------------------------------------------
    // Checks other than reset values and buffer limit start from a prefix byte followed by a command byte
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    reset_values_a: assert property ($fell(reset) |-> autoMode && !holdMode && repeatOn
        && debounceCount == DEBOUNCE_RST && bufCount == 0) else $error("reset values wrong");
    auto_on_a: assert property (cmdValid && cmdByte == CMD_PREFIX ##1 cmdValid
        && cmdByte == CMD_AUTO_ON |=> autoMode) else $error("auto mode not set");
    auto_off_a: assert property (cmdValid && cmdByte == CMD_PREFIX ##1 cmdValid
        && cmdByte == CMD_AUTO_OFF |=> !autoMode) else $error("auto mode not cleared");
    poll_pop_a: assert property (cmdValid && cmdByte == CMD_PREFIX ##1 cmdValid
        && cmdByte == CMD_POLL && bufCount != 0 |=> bufCount == $past(bufCount) - 4'h1)
        else $error("poll did not remove entry");
    more_flag_a: assert property (cmdValid && cmdByte == CMD_PREFIX ##1 cmdValid
        && cmdByte == CMD_POLL && bufCount != 0 |-> ##2 txValid
        && txByte[7] == ($past(bufCount, 2) > 1)) else $error("poll flag wrong");
    empty_poll_a: assert property (cmdValid && cmdByte == CMD_PREFIX ##1 cmdValid
        && cmdByte == CMD_POLL && bufCount == 0 |-> ##2 txValid && txByte == EMPTY_ANSWER)
        else $error("empty poll answer wrong");
    buf_clear_a: assert property (cmdValid && cmdByte == CMD_PREFIX ##1 cmdValid
        && cmdByte == CMD_CLEAR |-> ##[1:2] bufCount == 0) else $error("buffer not cleared");
    debounce_set_a: assert property (cmdValid && cmdByte == CMD_PREFIX ##1 cmdValid
        && cmdByte == CMD_DEBOUNCE ##1 cmdValid |=> debounceCount == $past(cmdByte))
        else $error("debounce count not taken");
    repeat_mode_a: assert property (cmdValid && cmdByte == CMD_PREFIX ##1 cmdValid
        && cmdByte == CMD_RPT_MODE ##1 cmdValid |=> holdMode == $past(cmdByte[0]) && repeatOn)
        else $error("repeat mode not taken");
    repeat_off_a: assert property (cmdValid && cmdByte == CMD_PREFIX ##1 cmdValid
        && cmdByte == CMD_RPT_OFF |=> !repeatOn) else $error("repeat not disabled");
    buf_limit_a: assert property (bufCount <= BUF_DEPTH)
        else $error("buffer overfull");
endmodule : keypad_scan_command_unit_checker

bind keypad_scan_command_unit keypad_scan_command_unit_checker keypad_scan_command_unit_checker_i (
    .mclk(mclk), .reset(reset), .cmdByte(cmdByte), .cmdValid(cmdValid), .txByte(txByte),
    .txValid(txValid), .autoMode(autoMode), .holdMode(holdMode), .repeatOn(repeatOn),
    .debounceCount(debounceCount), .bufCount(bufCount));

//--- testbench/host_link_model.sv
// Host side model: sends command bytes and collects bytes from the unit.
// Assumes its tasks are called at the falling edge of mclk.
`timescale 1ns/1ps
module host_link_model (
    input  wire logic       mclk,
    output logic      [7:0] cmdByte,
    output logic            cmdValid,
    input  wire logic [7:0] txByte,
    input  wire logic       txValid
);
    int         rxCnt  = 0;
    logic [7:0] rxLast = 8'h00;
    initial begin
        cmdByte  = 8'h00;
        cmdValid = 1'b0;
    end
    // Collect every byte sent to the host
    always @(posedge mclk) begin
        if (txValid === 1'b1) begin
            rxCnt  <= rxCnt + 1;
            rxLast <= txByte;
        end
    end
    // One byte per cycle, then idle with changing data
    task put(input logic [7:0] b);
        cmdByte  = b;
        cmdValid = 1'b1;
        @(negedge mclk);
    endtask : put
    task idle();
        cmdValid = 1'b0;
        cmdByte  = ~cmdByte;
    endtask : idle
    task cmd(input logic [7:0] c);
        put(8'hFE);
        put(c);
        idle();
    endtask : cmd
    task cmd_arg(input logic [7:0] c, input logic [7:0] a);
        put(8'hFE);
        put(c);
        put(a);
        idle();
    endtask : cmd_arg
    // All 25 down bytes then all 25 up bytes
    task assign_codes(input logic [7:0] dn [25], input logic [7:0] up [25]);
        put(8'hFE);
        put(8'hD5);
        for (int i = 0; i < 50; i++) put(i < 25 ? dn[i] : up[i-25]);
        idle();
    endtask : assign_codes
endmodule : host_link_model

//--- testbench/tb_keypad_scan_command_unit.sv
// Self-checking bench for the keypad command unit.
// Assumes short timing counts; the host model drives commands.
`timescale 1ns/1ps
module tb_keypad_scan_command_unit;
    import keypad_pkg::*;
    localparam int DLY = 40;
    localparam int RATE = 10;
    logic              mclk = 1'b0;
    logic              reset = 1'b1;
    logic [KEYS-1:0]   keyRaw = '0;
    logic [7:0]        cmdByte, txByte, debounceCount;
    logic              cmdValid, txValid, autoMode, holdMode, repeatOn;
    logic [BUF_CNT_W-1:0] bufCount;
    int                error_cnt = 0;
    int                n_compared = 0;
    int                cycleCnt = 0;
    int                start, lat;
    logic [7:0]        dn [25], up [25];
    always #2 mclk = ~mclk;
    keypad_scan_command_unit #(.STEP_CYC(4), .DELAY_CYC(DLY), .RATE_CYC(RATE))
        keypad_scan_command_unit_i (.mclk(mclk), .reset(reset), .cmdByte(cmdByte),
        .cmdValid(cmdValid), .keyRaw(keyRaw), .txByte(txByte), .txValid(txValid),
        .autoMode(autoMode), .holdMode(holdMode), .repeatOn(repeatOn),
        .debounceCount(debounceCount), .bufCount(bufCount));
    host_link_model host_link_model_i (.mclk(mclk), .cmdByte(cmdByte), .cmdValid(cmdValid),
        .txByte(txByte), .txValid(txValid));
    // --------------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------------
    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task close_out();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out
    task wait_tx(output int n);
        n = 0;
        start = host_link_model_i.rxCnt;
        while (host_link_model_i.rxCnt == start && n < 200) begin
            @(negedge mclk);
            n++;
        end
    endtask : wait_tx
    // Press, hold, release
    task tap(input int k, input logic [7:0] d, input logic [7:0] u);
        keyRaw[k] = 1'b1;
        wait_tx(lat);
        check(host_link_model_i.rxLast, d);
        repeat (60) @(negedge mclk);
        check(8'(host_link_model_i.rxCnt - start), 8'h01);
        keyRaw[k] = 1'b0;
        wait_tx(lat);
        check(host_link_model_i.rxLast, u);
    endtask : tap
    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task t_typematic();
        keyRaw[3] = 1'b1;
        wait_tx(lat);
        check(host_link_model_i.rxLast, 8'h44);
        check(8'(lat >= 35 && lat <= 45), 8'h01);
        repeat (DLY - 5) @(negedge mclk);
        check(8'(host_link_model_i.rxCnt - start), 8'h01);
        repeat (2 * RATE + 10) @(negedge mclk);
        check(8'(host_link_model_i.rxCnt - start), 8'h04);
        check(host_link_model_i.rxLast, 8'h44);
        keyRaw[3] = 1'b0;
        repeat (45) @(negedge mclk);
        start = host_link_model_i.rxCnt;
        repeat (60) @(negedge mclk);
        check(8'(host_link_model_i.rxCnt - start), 8'h00);
        $display("test typematic done, mismatches %0d", error_cnt);
    endtask : t_typematic
    task t_hold();
        host_link_model_i.cmd_arg(CMD_RPT_MODE, 8'h01);
        check(8'(holdMode), 8'h01);
        tap(0, 8'h41, 8'h61);
        tap(24, 8'h59, 8'h79);
        $display("test hold done, mismatches %0d", error_cnt);
    endtask : t_hold
    task t_buffer();
        host_link_model_i.cmd(CMD_AUTO_OFF);
        host_link_model_i.cmd_arg(CMD_DEBOUNCE, 8'h01);
        host_link_model_i.cmd(CMD_RPT_OFF);
        check(debounceCount, 8'h01);
        start = host_link_model_i.rxCnt;
        for (int i = 0; i < 11; i++) begin
            keyRaw[i] = 1'b1;
            repeat (20) @(negedge mclk);
            keyRaw[i] = 1'b0;
            repeat (20) @(negedge mclk);
        end
        check(8'(bufCount), 8'h0A);
        check(8'(host_link_model_i.rxCnt - start), 8'h00);
        for (int i = 0; i < 11; i++) begin
            host_link_model_i.cmd(CMD_POLL);
            repeat (4) @(negedge mclk);
            check(host_link_model_i.rxLast, i > 9 ? 8'h00 :
                (i < 9 ? MORE_FLAG : 8'h00) | (DOWN_BASE + 8'(i)));
        end
        keyRaw[5:4] = 2'b11;
        repeat (20) @(negedge mclk);
        check(8'(bufCount), 8'h02);
        host_link_model_i.cmd(CMD_CLEAR);
        repeat (3) @(negedge mclk);
        check(8'(bufCount), 8'h00);
        keyRaw[5:4] = 2'b00;
        $display("test buffer done, mismatches %0d", error_cnt);
    endtask : t_buffer
    task t_assign();
        host_link_model_i.cmd(CMD_AUTO_ON);
        host_link_model_i.cmd_arg(CMD_RPT_MODE, 8'h01);
        host_link_model_i.cmd(CMD_CLEAR);
        repeat (20) @(negedge mclk);
        for (int i = 0; i < 25; i++) begin
            dn[i] = KEEP_CODE;
            up[i] = KEEP_CODE;
        end
        dn[0] = 8'h30;
        dn[12] = 8'h2A;
        up[24] = 8'h7A;
        host_link_model_i.assign_codes(dn, up);
        tap(0, 8'h30, 8'h61);
        tap(12, 8'h2A, 8'h6D);
        tap(24, 8'h59, 8'h7A);
        $display("test assign done, mismatches %0d", error_cnt);
    endtask : t_assign
    // --------------------------------------------------------------
    // Main sequence and timeout
    // --------------------------------------------------------------
    // Cut a hang short
    always @(posedge mclk) begin
        cycleCnt++;
        if (cycleCnt == 20000) begin
            error_cnt++;
            close_out();
        end
    end
    // Reset, then each scenario in turn
    initial begin
        repeat (16) @(negedge mclk);
        reset = 1'b0;
        @(negedge mclk);
        check(8'({autoMode, holdMode, repeatOn}), 8'h05);
        check(debounceCount, 8'h08);
        check(8'(bufCount), 8'h00);
        t_typematic();
        t_hold();
        t_buffer();
        t_assign();
        close_out();
    end
endmodule : tb_keypad_scan_command_unit
